// *** hdl/gauge_cmd_map.vh ***
// Constants for the gauge command and mode control block
`ifndef GAUGE_CMD_MAP_VH
`define GAUGE_CMD_MAP_VH
// Word command codes
`define CMD_FACTORY 8'h00
`define CMD_LOW_CAP 8'h01
`define CMD_LOW_TIME 8'h02
`define CMD_OPTIONS 8'h03
// Factory command word values
`define FC_ABORT_CAL 16'h0660
`define FC_PROG_EE 16'h0606
`define FC_REVISION 16'h07e6
// Battery slave address, write form
`define BATT_ADDR 8'h16
// Option word bit positions
`define OPT_RELEARN 7
`define OPT_CTRL_EN 8
`define OPT_CELL 9
`define OPT_ALARM_OFF 13
`define OPT_CHG_OFF 14
`define OPT_CAP_UNIT 15
`define OPT_WR_MASK 16'he400
// Timing, clock 10 MHz
`define CLK_HZ 10000000
`define ABORT_MS 20
`define EE_PWR_MS 900
`define POLL_MS 150
`define ALARM_HOLD_S 55
`define BUSOFF_MS 2500
`define BUSOFF_CLR_MS 130
`define STORE_S 20
`define RELEARN_CYCLES 20
`define ZERO16 16'h0000
`endif

// *** hdl/gauge_cmd_ctrl.v ***
// Command and mode control of a battery gas gauge
`include "gauge_cmd_map.vh"
`default_nettype none
module gauge_cmd_ctrl #(
	parameter [15:0] REVISION = 16'h0001,
	parameter [31:0] POLL_CYC = (`POLL_MS * (`CLK_HZ / 1000)) - 1,
	parameter [31:0] HOLD_CYC = `ALARM_HOLD_S * `CLK_HZ,
	parameter [31:0] BUSOFF_CYC = `BUSOFF_MS * (`CLK_HZ / 1000),
	parameter [31:0] STORE_CYC = `STORE_S * `CLK_HZ
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Decoded word command port
	input wire cmd_wr,
	input wire cmd_rd,
	input wire [7:0] cmd_code,
	input wire [15:0] cmd_wdata,
	output reg [15:0] cmd_rdata,
	// Host bus address seen and line levels (pins)
	input wire addr_seen,
	input wire [7:0] addr_byte,
	input wire bus_clk_pin,
	input wire bus_dat_pin,
	// EEPROM defaults and sealed state
	input wire [15:0] ee_low_cap,
	input wire [15:0] ee_low_time,
	input wire sealed,
	// Calibration engine
	input wire cal_active,
	input wire cal_done,
	input wire cal_stored,
	input wire store_requested,
	output reg cal_abort,
	output reg offset_corr_en,
	output reg offset_correction_valid,
	output reg save_offsets,
	output reg enter_storage,
	// Gauge measurements
	input wire [15:0] charge_left_value,
	input wire [15:0] mean_runtime_estimate,
	input wire cycle_count_tick,
	input wire full_charge_update,
	input wire learn_complete,
	// Bridge and broadcast controls
	output reg bridge_on,
	output reg ee_power,
	output wire monitor_en,
	output wire alarm_broadcast_en,
	output wire charge_broadcast_en,
	output wire capacity_unit_10mw,
	output reg cap_alarm,
	output reg time_alarm
);
	// Thresholds and factory word
	reg [15:0] low_cap_q;
	reg [15:0] low_time_q;
	reg [15:0] factory_q;
	// Mode word state and relearn tracking
	reg init_q;
	reg relearn_q;
	reg alarm_off_q;
	reg chg_off_q;
	reg unit_q;
	reg [4:0] stale_q;
	// Poll, hold, bus-off and storage timers
	reg [31:0] poll_q;
	reg [31:0] hold_q;
	reg [31:0] off_q;
	reg [31:0] store_q;
	reg bus_off_q;
	reg storing_q;
	// Two-stage synchronisers for the host bus lines
	reg [1:0] sclk_s;
	reg [1:0] sdat_s;
	wire lines_low;
	wire opt_wr;
	wire poll_hit;

	// Write strobe for one command code
	function wr_to(input [7:0] c);
		wr_to = cmd_wr & (cmd_code == c);
	endfunction

	assign lines_low = ~sclk_s[1] & ~sdat_s[1];
	assign opt_wr = wr_to(`CMD_OPTIONS);
	assign poll_hit = (poll_q >= POLL_CYC);

	assign monitor_en = ~bridge_on;
	assign alarm_broadcast_en = ~alarm_off_q & ~(|hold_q);
	assign charge_broadcast_en = ~chg_off_q;
	assign capacity_unit_10mw = unit_q;

	// Only the second stage is read, so a metastable first stage never reaches logic
	always @(posedge clk) begin
		sclk_s <= {sclk_s[0], bus_clk_pin};
		sdat_s <= {sdat_s[0], bus_dat_pin};
	end
	always @* begin
		case (cmd_code)
			`CMD_FACTORY: cmd_rdata = factory_q;
			`CMD_LOW_CAP: cmd_rdata = low_cap_q;
			`CMD_LOW_TIME: cmd_rdata = low_time_q;
			`CMD_OPTIONS: cmd_rdata = {unit_q, chg_off_q, alarm_off_q, 5'h00, relearn_q, 7'h00};
			default: cmd_rdata = `ZERO16;
		endcase
	end

	always @(posedge clk) begin
		if (!nrst) begin
			init_q <= 1'b1;
			low_cap_q <= `ZERO16;
			low_time_q <= `ZERO16;
		end else if (init_q) begin
			init_q <= 1'b0;
			low_cap_q <= ee_low_cap;
			low_time_q <= ee_low_time;
		end else begin
			// Host writes; a write in the load cycle is lost
			if (wr_to(`CMD_LOW_CAP))
				low_cap_q <= cmd_wdata;
			if (wr_to(`CMD_LOW_TIME))
				low_time_q <= cmd_wdata;
		end
	end

	always @(posedge clk) begin
		if (!nrst) begin
			factory_q <= `ZERO16;
			bridge_on <= 1'b0;
			ee_power <= 1'b0;
			cal_abort <= 1'b0;
			offset_corr_en <= 1'b1;
			offset_correction_valid <= 1'b0;
		end else begin
			cal_abort <= 1'b0;
			if (wr_to(`CMD_FACTORY)) begin
				factory_q <= cmd_wdata;
				if (cmd_wdata == `FC_ABORT_CAL)
					cal_abort <= cal_active;
				if (cmd_wdata == `FC_REVISION)
					factory_q <= REVISION;
				if (cmd_wdata == `FC_PROG_EE && !sealed) begin
					bridge_on <= 1'b1;
					ee_power <= 1'b1;
				end
			end
			// Battery address ends bridge, winning over a program command
			if (bridge_on && addr_seen && addr_byte == `BATT_ADDR) begin
				bridge_on <= 1'b0;
				ee_power <= 1'b0;
			end
			// Offset valid tracking; a stored result wins over an abort
			if (cal_stored) begin
				offset_correction_valid <= 1'b1;
				offset_corr_en <= 1'b1;
			end else begin
				if (cal_active)
					offset_correction_valid <= 1'b0;
				// Correction off when calibration is aborted
				if (wr_to(`CMD_FACTORY) && cmd_wdata == `FC_ABORT_CAL && cal_active)
					offset_corr_en <= 1'b0;
			end
		end
	end

	always @(posedge clk) begin
		if (!nrst) begin
			store_q <= 32'h0;
			storing_q <= 1'b0;
			save_offsets <= 1'b0;
			enter_storage <= 1'b0;
		end else begin
			save_offsets <= 1'b0;
			enter_storage <= 1'b0;
			if (cal_done && store_requested) begin
				save_offsets <= 1'b1;
				storing_q <= 1'b1;
				store_q <= 32'h0;
			end else if (storing_q) begin
				if (store_q >= STORE_CYC - 1) begin
					storing_q <= 1'b0;
					enter_storage <= 1'b1;
				end else
					store_q <= store_q + 32'h1;
			end
		end
	end

	always @(posedge clk) begin
		if (!nrst) begin
			stale_q <= 5'h00;
			relearn_q <= 1'b0;
		end else begin
			// Cycles since the last capacity update, saturating
			if (full_charge_update)
				stale_q <= 5'h00;
			else if (cycle_count_tick && stale_q != 5'h1f)
				stale_q <= stale_q + 5'h01;
			// Set wins over a learn completion in the same cycle
			if (init_q || stale_q >= `RELEARN_CYCLES)
				relearn_q <= 1'b1;
			else if (learn_complete)
				relearn_q <= 1'b0;
		end
	end

	always @(posedge clk) begin
		if (!nrst) begin
			alarm_off_q <= 1'b0;
			chg_off_q <= 1'b0;
			unit_q <= 1'b0;
			poll_q <= 32'h0;
			hold_q <= 32'h0;
			off_q <= 32'h0;
			bus_off_q <= 1'b0;
		end else begin
			// Bus off after both lines stay low long enough
			if (!lines_low) begin
				off_q <= 32'h0;
				bus_off_q <= 1'b0;
			end else if (off_q >= BUSOFF_CYC - 1)
				bus_off_q <= 1'b1;
			else
				off_q <= off_q + 32'h1;
			if (poll_hit)
				poll_q <= 32'h0;
			else
				poll_q <= poll_q + 32'h1;
			// Bus off returns mode bits to defaults, over any write
			if (bus_off_q) begin
				alarm_off_q <= 1'b0;
				chg_off_q <= 1'b0;
				unit_q <= 1'b0;
				hold_q <= 32'h0;
			end else begin
				// Only bits 13 to 15 are kept
				if (opt_wr) begin
					alarm_off_q <= cmd_wdata[`OPT_ALARM_OFF];
					chg_off_q <= cmd_wdata[`OPT_CHG_OFF];
					unit_q <= cmd_wdata[`OPT_CAP_UNIT];
				end
				// Poll clears the bit and restarts the hold; a write then wins
				if (poll_hit) begin
					if (alarm_off_q && !opt_wr) begin
						alarm_off_q <= 1'b0;
						hold_q <= HOLD_CYC;
					end
				end else if (hold_q != 32'h0)
					hold_q <= hold_q - 32'h1;
			end
		end
	end

	always @(posedge clk) begin
		if (!nrst) begin
			cap_alarm <= 1'b0;
			time_alarm <= 1'b0;
		end else begin
			// A zero threshold never trips, as nothing is below zero
			cap_alarm <= (low_cap_q != `ZERO16) && (charge_left_value < low_cap_q)
				&& alarm_broadcast_en;
			time_alarm <= (low_time_q != `ZERO16) && (mean_runtime_estimate < low_time_q)
				&& alarm_broadcast_en;
		end
	end
endmodule
`default_nettype wire

// *** testbench/gauge_cmd_checker.sv ***
// Port checks for the gauge command and mode control block
`default_nettype none
module gauge_cmd_checker #(
	parameter [15:0] REVISION = 16'h0001
) (
	input wire logic clk, nrst, cmd_wr, sealed, cal_active, addr_seen, bridge_on, ee_power,
	input wire logic monitor_en, offset_corr_en, offset_correction_valid,
	input wire logic capacity_unit_10mw, charge_broadcast_en,
	input wire logic [7:0] cmd_code, addr_byte,
	input wire logic [15:0] cmd_wdata, cmd_rdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic fc = cmd_wr && cmd_code == 8'h00;
	chk_monitor_held: assert property (monitor_en != bridge_on)
		else $error("monitor on while bridged");
	chk_bridge_open: assert property (fc && cmd_wdata == 16'h0606 && !sealed && !addr_seen
		|=> bridge_on && ee_power) else $error("bridge not opened");
	chk_sealed_block: assert property (fc && cmd_wdata == 16'h0606 && sealed && !bridge_on
		|=> !bridge_on) else $error("bridge opened while sealed");
	chk_bridge_close: assert property (bridge_on && addr_seen && addr_byte == 8'h16 && !cmd_wr
		|=> !bridge_on) else $error("bridge kept");
	chk_abort_corr: assert property (fc && cmd_wdata == 16'h0660 && cal_active
		|=> !offset_corr_en) else $error("correction kept on");
	chk_mode_fixed: assert property (cmd_code == 8'h03 |-> (cmd_rdata & 16'h037f) == 16'h0000)
		else $error("fixed mode bits set");
	chk_mode_outs: assert property (cmd_code == 8'h03 |-> capacity_unit_10mw == cmd_rdata[15]
		&& charge_broadcast_en == !cmd_rdata[14]) else $error("mode outputs differ");
	chk_valid_clear: assert property ($rose(cal_active) |=> !offset_correction_valid)
		else $error("valid kept at start");
	chk_rev_load: assert property (fc && cmd_wdata == 16'h07e6 ##1 cmd_code == 8'h00 && !cmd_wr
		|-> cmd_rdata == REVISION) else $error("revision missing");
endmodule
bind gauge_cmd_ctrl gauge_cmd_checker #(.REVISION(REVISION)) u_gauge_cmd_checker (.*);
`default_nettype wire

// *** testbench/host_bus_model.sv ***
// Host bus partner: address bytes and line levels
`default_nettype none
module host_bus_model (
	input wire logic clk,
	output logic addr_seen, bus_clk_pin, bus_dat_pin,
	output logic [7:0] addr_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy = 1'h0;
	initial begin
		{addr_seen, bus_clk_pin, bus_dat_pin, addr_byte} = {3'h3, 8'h5a};
	end
	// Byte is junk between frames, so it keeps changing
	always @(posedge clk) if (!busy) addr_byte <= #1 ~addr_byte;
	// quiet gap after the last EEPROM write
	task automatic send_addr(input logic [7:0] a, input int gap);
		busy = 1'h1;
		repeat (gap) @(posedge clk);
		#1 {addr_byte, addr_seen} = {a, 1'h1};
		@(posedge clk);
		#1 {addr_seen, busy} = 2'h0;
	endtask
	task automatic bus_off(input int cyc);
		{bus_clk_pin, bus_dat_pin} = 2'h0;
		repeat (cyc) @(posedge clk);
		#1 {bus_clk_pin, bus_dat_pin} = 2'h3;
		// Let the synchronisers see the lines high before the host talks again
		repeat (4) @(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// *** testbench/gauge_cmd_ctrl_tb.sv ***
// Self-checking bench for the gauge command and mode control block
`default_nettype none
module gauge_cmd_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] REV = 16'h00a5; // Arbitrary revision value
	logic clk = 1'h0, nrst = 1'h0, cmd_wr = 1'h0, cmd_rd = 1'h0, sealed = 1'h0, cal_active = 1'h0;
	logic cal_done = 1'h0, cal_stored = 1'h0, store_requested = 1'h0, cycle_count_tick = 1'h0;
	logic full_charge_update = 1'h0, learn_complete = 1'h0;
	logic [7:0] cmd_code = 8'h00, addr_byte;
	logic [15:0] cmd_wdata = 16'h0000, ee_low_cap = 16'h1234, ee_low_time = 16'h0321, cmd_rdata;
	logic [15:0] charge_left_value = 16'hffff, mean_runtime_estimate = 16'hffff;
	logic addr_seen, bus_clk_pin, bus_dat_pin, cal_abort, offset_corr_en, offset_correction_valid;
	logic save_offsets, enter_storage, bridge_on, ee_power, monitor_en, alarm_broadcast_en;
	logic charge_broadcast_en, capacity_unit_10mw, cap_alarm, time_alarm;
	int fails = 0, checked = 0;
	always #50 clk = ~clk;
	host_bus_model u_host_bus_model (.*);
	gauge_cmd_ctrl #(.REVISION(REV), .POLL_CYC(10), .HOLD_CYC(50), .BUSOFF_CYC(20),
		.STORE_CYC(30)) u_gauge_cmd_ctrl (.*);
	task automatic cmp(input logic [15:0] got, exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Extra idle cycle so strobes never toggle twice in one step
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		{cmd_code, cmd_wdata, cmd_wr} = {c, d, 1'h1};
		@(posedge clk);
		#1 cmd_wr = 1'h0;
		@(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] exp);
		{cmd_code, cmd_rd} = {c, 1'h1};
		#10 cmp(cmd_rdata, exp);
		@(posedge clk);
		#1 cmd_rd = 1'h0;
		@(posedge clk);
		#1;
	endtask
	task automatic t_init;
		rd(8'h01, 16'h1234);
		rd(8'h02, 16'h0321);
		rd(8'h03, 16'h0080);
		learn_complete = 1'h1;
		@(posedge clk);
		#1 learn_complete = 1'h0;
		rd(8'h03, 16'h0000);
		wr(8'h01, 16'hfffe);
		rd(8'h01, 16'hfffe);
	endtask
	task automatic t_alarm;
		wr(8'h01, 16'h0064);
		charge_left_value = 16'h0032;
		wr(8'h02, 16'h000a);
		mean_runtime_estimate = 16'h0005;
		repeat (3) @(posedge clk);
		#1 cmp({14'h0, cap_alarm, time_alarm}, 16'h0003);
		wr(8'h01, 16'h0000);
		wr(8'h02, 16'h0000);
		repeat (3) @(posedge clk);
		#1 cmp({14'h0, cap_alarm, time_alarm}, 16'h0000);
	endtask
	task automatic t_mode;
		wr(8'h03, 16'hdfff);
		rd(8'h03, 16'hc000);
		cmp({14'h0, charge_broadcast_en, capacity_unit_10mw}, 16'h0001);
		u_host_bus_model.bus_off(30);
		rd(8'h03, 16'h0000);
		wr(8'h03, 16'h2000);
		cmp({15'h0, alarm_broadcast_en}, 16'h0000);
		repeat (120) @(posedge clk);
		#1 cmp({15'h0, alarm_broadcast_en}, 16'h0001);
		rd(8'h03, 16'h0000);
	endtask
	task automatic t_cmds;
		sealed = 1'h1;
		wr(8'h00, 16'h0606);
		cmp({15'h0, bridge_on}, 16'h0000);
		sealed = 1'h0;
		wr(8'h00, 16'h0606);
		cmp({13'h0, bridge_on, ee_power, monitor_en}, 16'h0006);
		u_host_bus_model.send_addr(8'h16, 5);
		cmp({14'h0, bridge_on, monitor_en}, 16'h0001);
		wr(8'h00, 16'h07e6);
		rd(8'h00, REV);
		cal_active = 1'h1;
		wr(8'h00, 16'h0660);
		cmp({15'h0, offset_corr_en}, 16'h0000);
		cal_active = 1'h0;
	endtask
	task automatic t_cal;
		// Storage request and seal both arrive before calibration ends
		cal_active = 1'h1;
		store_requested = 1'h1;
		sealed = 1'h1;
		@(posedge clk);
		#1 cmp({15'h0, offset_correction_valid}, 16'h0000);
		cal_done = 1'h1;
		@(posedge clk);
		#1 {cal_done, cal_active, store_requested} = 3'h0;
		cmp({15'h0, save_offsets}, 16'h0001);
		cal_stored = 1'h1;
		@(posedge clk);
		#1 cal_stored = 1'h0;
		cmp({14'h0, offset_correction_valid, offset_corr_en}, 16'h0003);
		repeat (28) @(posedge clk);
		#1 cmp({15'h0, enter_storage}, 16'h0000);
		@(posedge clk);
		#1 cmp({15'h0, enter_storage}, 16'h0001);
		sealed = 1'h0;
		cycle_count_tick = 1'h1;
		repeat (20) @(posedge clk);
		#1 cycle_count_tick = 1'h0;
		@(posedge clk);
		#1 rd(8'h03, 16'h0080);
		full_charge_update = 1'h1;
		@(posedge clk);
		#1 {full_charge_update, learn_complete} = 2'h1;
		@(posedge clk);
		#1 learn_complete = 1'h0;
		rd(8'h03, 16'h0000);
	endtask
	task automatic give_verdict;
		if (fails == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge clk);
		#1 nrst = 1'h1;
		@(posedge clk);
		#1;
		t_init();
		t_alarm();
		t_mode();
		t_cmds();
		t_cal();
		give_verdict();
	end
endmodule
`default_nettype wire
